// [common/rtcs_regs.svh]
`ifndef RTCS_REGS_SVH
`define RTCS_REGS_SVH

// ----------------------------------------
// bus addressing and byte space
// ----------------------------------------
`define RTCS_SLAVE_ADDR 7'h68
`define RTCS_SPACE_BYTES 64
`define RTCS_CLOCK_BYTES 8
`define RTCS_PTR_RESET 6'h00
`define RTCS_RW_BIT 0
`define RTCS_SYNC_STAGES 2

`endif

// [common/rtcs_pkg.sv]
package rtcs_pkg;

    typedef enum {
        ST_IDLE,
        ST_DEVADDR,
        ST_DEVACK,
        ST_WORDADDR,
        ST_WORDACK,
        ST_WRDATA,
        ST_WRACK,
        ST_RDDATA,
        ST_RDACK
    } rtcs_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } rtcs_bus_ev_t;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rtcs_mem_req_t;

endpackage

// [verilog/rtcs_line_sync.sv]
`timescale 1ns/10ps
`include "rtcs_regs.svh"

module rtcs_line_sync (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic enable_in,
    output rtcs_pkg::rtcs_bus_ev_t ev_out
);
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;
    logic en_d_r;

    // ----------------------------------------
    // two-stage synchronisers, idle high
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            en_d_r <= 1'b0;
        end else begin
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
            en_d_r <= enable_in;
        end
    end

    // ----------------------------------------
    // edge and condition decode
    // ----------------------------------------
    always_comb begin
        ev_out.sda = sda_sync_r[1];
        ev_out.rise = en_d_r && !scl_d_r && scl_sync_r[1];
        ev_out.fall = en_d_r && scl_d_r && !scl_sync_r[1];
        ev_out.start = en_d_r && scl_d_r && scl_sync_r[1] && sda_d_r && !sda_sync_r[1];
        ev_out.stop = en_d_r && scl_d_r && scl_sync_r[1] && !sda_d_r && sda_sync_r[1];
    end
endmodule

// [verilog/rtcs_byte_mem.sv]
`timescale 1ns/10ps
`include "rtcs_regs.svh"

module rtcs_byte_mem #(
    parameter int DEPTH = `RTCS_SPACE_BYTES
) (
    input wire logic core_clk_in,
    input rtcs_pkg::rtcs_mem_req_t req_in,
    input wire logic [5:0] raddr_in,
    output logic [7:0] rdata_out
);
    initial begin
        if (DEPTH != 64) begin
            $error("depth must be 64");
        end
    end

    // clock/calendar bytes 0..7 then general ram
    logic [7:0] mem_r [DEPTH];

    always_ff @(posedge core_clk_in) begin
        if (req_in.we) begin
            mem_r[req_in.addr] <= req_in.wdata;
        end
    end

    assign rdata_out = mem_r[raddr_in];
endmodule

// [verilog/rtcs_slave_port.sv]
`timescale 1ns/10ps
`include "rtcs_regs.svh"

module rtcs_slave_port #(
    parameter int SPACE = `RTCS_SPACE_BYTES
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic supply_ok_in,
    output logic [5:0] ptr_out,
    output logic busy_out
);
    initial begin
        if (SPACE != 64) begin
            $error("space must be 64 bytes");
        end
    end

    rtcs_pkg::rtcs_state_t state_r;
    rtcs_pkg::rtcs_bus_ev_t ev;
    rtcs_pkg::rtcs_mem_req_t mem_req;
    logic [1:0] pwr_sync_r;
    logic pwr_ok;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic [5:0] ptr_r;
    logic [7:0] rdata;
    logic [5:0] raddr;
    logic drive_low_r;
    logic ack_seen_r;
    logic rd_mode_r;

    function automatic logic [5:0] ptr_inc(input logic [5:0] p);
        ptr_inc = (p == 6'(SPACE - 1)) ? 6'h00 : 6'(p + 6'h01);
    endfunction

    // ----------------------------------------
    // supply monitor synchroniser
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            pwr_sync_r <= 2'h0;
        end else begin
            pwr_sync_r <= {pwr_sync_r[0], supply_ok_in};
        end
    end
    assign pwr_ok = pwr_sync_r[1];
    assign raddr = (state_r == rtcs_pkg::ST_RDACK && ack_seen_r) ? ptr_inc(ptr_r) : ptr_r;

    rtcs_line_sync u_sync (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .enable_in(pwr_ok),
        .ev_out(ev)
    );

    rtcs_byte_mem #(
        .DEPTH(SPACE)
    ) u_mem (
        .core_clk_in(core_clk_in),
        .req_in(mem_req),
        .raddr_in(raddr),
        .rdata_out(rdata)
    );

    // ----------------------------------------
    // bit counter and shift register
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in || !pwr_ok) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else if (ev.start) begin
            bit_cnt_r <= 4'h0;
        end else if (ev.rise) begin
            if (bit_cnt_r < 4'h8) begin
                shift_r <= {shift_r[6:0], ev.sda};
            end
            bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : 4'(bit_cnt_r + 4'h1);
        end
    end

    // ----------------------------------------
    // protocol state machine
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in || !pwr_ok) begin
            state_r <= rtcs_pkg::ST_IDLE;
            rd_mode_r <= 1'b0;
            ack_seen_r <= 1'b0;
        end else if (ev.stop) begin
            state_r <= rtcs_pkg::ST_IDLE;
        end else if (ev.start) begin
            state_r <= rtcs_pkg::ST_DEVADDR;
        end else begin
            case (state_r)
                rtcs_pkg::ST_IDLE: begin
                    state_r <= rtcs_pkg::ST_IDLE;
                end
                rtcs_pkg::ST_DEVADDR: begin
                    if (ev.fall && bit_cnt_r == 4'h8) begin
                        if (shift_r[7:1] == `RTCS_SLAVE_ADDR) begin
                            state_r <= rtcs_pkg::ST_DEVACK;
                            rd_mode_r <= shift_r[`RTCS_RW_BIT];
                        end else begin
                            state_r <= rtcs_pkg::ST_IDLE;
                        end
                    end
                end
                rtcs_pkg::ST_DEVACK: begin
                    if (ev.fall && bit_cnt_r == 4'h0) begin
                        state_r <= rd_mode_r ? rtcs_pkg::ST_RDDATA
                                             : rtcs_pkg::ST_WORDADDR;
                    end
                end
                rtcs_pkg::ST_WORDADDR: begin
                    if (ev.fall && bit_cnt_r == 4'h8) begin
                        state_r <= rtcs_pkg::ST_WORDACK;
                    end
                end
                rtcs_pkg::ST_WORDACK: begin
                    if (ev.fall && bit_cnt_r == 4'h0) begin
                        state_r <= rtcs_pkg::ST_WRDATA;
                    end
                end
                rtcs_pkg::ST_WRDATA: begin
                    if (ev.fall && bit_cnt_r == 4'h8) begin
                        state_r <= rtcs_pkg::ST_WRACK;
                    end
                end
                rtcs_pkg::ST_WRACK: begin
                    if (ev.fall && bit_cnt_r == 4'h0) begin
                        state_r <= rtcs_pkg::ST_WRDATA;
                    end
                end
                rtcs_pkg::ST_RDDATA: begin
                    if (ev.fall && bit_cnt_r == 4'h8) begin
                        state_r <= rtcs_pkg::ST_RDACK;
                    end
                end
                rtcs_pkg::ST_RDACK: begin
                    if (ev.rise) begin
                        ack_seen_r <= !ev.sda;
                    end
                    if (ev.fall && bit_cnt_r == 4'h0) begin
                        state_r <= ack_seen_r ? rtcs_pkg::ST_RDDATA
                                              : rtcs_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= rtcs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // address pointer and memory write
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in || !pwr_ok) begin
            ptr_r <= `RTCS_PTR_RESET;
        end else if (ev.fall && bit_cnt_r == 4'h8 && !ev.start && !ev.stop) begin
            if (state_r == rtcs_pkg::ST_WORDADDR) begin
                ptr_r <= shift_r[5:0];
            end
        end else if (ev.fall && bit_cnt_r == 4'h0) begin
            if (state_r == rtcs_pkg::ST_WRACK) begin
                ptr_r <= ptr_inc(ptr_r);
            end else if (state_r == rtcs_pkg::ST_RDACK && ack_seen_r) begin
                ptr_r <= ptr_inc(ptr_r);
            end
        end
    end

    always_comb begin
        mem_req.we = pwr_ok && ev.fall && bit_cnt_r == 4'h8
                     && state_r == rtcs_pkg::ST_WRDATA;
        mem_req.addr = ptr_r;
        mem_req.wdata = shift_r;
    end

    // ----------------------------------------
    // data line driver, changes on scl fall; cleared on start, stop or supply loss
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in || !pwr_ok) begin
            drive_low_r <= 1'b0;
        end else if (ev.start || ev.stop) begin
            drive_low_r <= 1'b0;
        end else if (ev.fall) begin
            case (state_r)
                rtcs_pkg::ST_DEVADDR: begin
                    drive_low_r <= bit_cnt_r == 4'h8
                                   && shift_r[7:1] == `RTCS_SLAVE_ADDR;
                end
                rtcs_pkg::ST_WORDADDR, rtcs_pkg::ST_WRDATA: begin
                    drive_low_r <= bit_cnt_r == 4'h8;
                end
                rtcs_pkg::ST_DEVACK: begin
                    drive_low_r <= rd_mode_r && !rdata[7];
                end
                rtcs_pkg::ST_RDDATA: begin
                    drive_low_r <= bit_cnt_r < 4'h8 && !rdata[3'(4'h7 - bit_cnt_r)];
                end
                rtcs_pkg::ST_RDACK: begin
                    drive_low_r <= ack_seen_r && !rdata[7];
                end
                default: begin
                    drive_low_r <= 1'b0;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n_out = !drive_low_r;
    assign ptr_out = ptr_r;
    assign busy_out = state_r != rtcs_pkg::ST_IDLE;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_wrap;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (pwr_ok && ev.fall && bit_cnt_r == 4'h0 && state_r == rtcs_pkg::ST_WRACK
         && ptr_r == 6'h3f) |=> ptr_r == 6'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

    property p_pwr_clear;
        @(posedge core_clk_in) disable iff (!nrst_in)
        !pwr_ok |=> ptr_r == 6'h00 && state_r == rtcs_pkg::ST_IDLE && sda_oe_n_out;
    endproperty
    a_pwr_clear: assert property (p_pwr_clear) else $error("low supply not handled");

    property p_no_write_low;
        @(posedge core_clk_in) disable iff (!nrst_in)
        !pwr_ok |-> !mem_req.we;
    endproperty
    a_no_write_low: assert property (p_no_write_low) else $error("write while low");

    property p_start_addr;
        @(posedge core_clk_in) disable iff (!nrst_in)
        pwr_ok && ev.start |=> state_r == rtcs_pkg::ST_DEVADDR;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not taken");

    property p_stop_idle;
        @(posedge core_clk_in) disable iff (!nrst_in)
        ev.stop |=> !busy_out && sda_oe_n_out;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

    property p_ack_low;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state_r == rtcs_pkg::ST_WRACK && ev.rise) |-> !sda_oe_n_out;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("data ack missing");

    property p_rd_release;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state_r == rtcs_pkg::ST_RDACK && ev.rise) |-> sda_oe_n_out;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("drove during master ack");

    property p_drive_on_low;
        @(posedge core_clk_in) disable iff (!nrst_in)
        $changed(sda_oe_n_out) && !$past(ev.start) && !$past(ev.stop) && $past(pwr_ok)
        |-> $past(ev.fall);
    endproperty
    a_drive_on_low: assert property (p_drive_on_low) else $error("data moved at clock high");

    property p_rd_hold;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state_r == rtcs_pkg::ST_RDACK && !ack_seen_r && ev.fall && bit_cnt_r == 4'h0)
        |=> ptr_r == $past(ptr_r) && sda_oe_n_out;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("nack handled wrong");

    property p_match;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state_r == rtcs_pkg::ST_DEVADDR && ev.fall && bit_cnt_r == 4'h8 && !ev.stop
         && shift_r[7:1] != `RTCS_SLAVE_ADDR) |=> !busy_out;
    endproperty
    a_match: assert property (p_match) else $error("foreign address taken");

    c_write: cover property (@(posedge core_clk_in) mem_req.we);
    c_read_ack: cover property (@(posedge core_clk_in)
        state_r == rtcs_pkg::ST_RDACK && ev.fall && ack_seen_r);
    c_wrap: cover property (@(posedge core_clk_in) $past(ptr_r) == 6'h3f && ptr_r == 6'h00);
    c_pwr_drop: cover property (@(posedge core_clk_in) busy_out ##1 !pwr_ok);
endmodule

// [test/rtcs_bus_master.sv]
`timescale 1ns/10ps

// ----------------------------------------
// two-wire bus master, open drain on data
// ----------------------------------------
module rtcs_bus_master (
    input wire logic core_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_pull_out
);
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end

    task automatic half;
        repeat (6) @(negedge core_clk_in);
    endtask

    task automatic bit_out(input logic b);
        @(negedge core_clk_in);
        sda_pull_out = ~b;
        repeat (5) @(negedge core_clk_in);
        scl_out = 1'b1;
        half();
        scl_out = 1'b0;
    endtask

    task automatic bit_in(output logic b);
        @(negedge core_clk_in);
        sda_pull_out = 1'b0;
        repeat (5) @(negedge core_clk_in);
        scl_out = 1'b1;
        repeat (3) @(negedge core_clk_in);
        b = sda_in;
        repeat (3) @(negedge core_clk_in);
        scl_out = 1'b0;
    endtask

    task automatic start;
        @(negedge core_clk_in);
        sda_pull_out = 1'b0;
        half();
        scl_out = 1'b1;
        half();
        sda_pull_out = 1'b1;
        half();
        scl_out = 1'b0;
    endtask

    task automatic stop;
        @(negedge core_clk_in);
        sda_pull_out = 1'b1;
        half();
        scl_out = 1'b1;
        half();
        sda_pull_out = 1'b0;
        half();
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(a);
        ack = ~a;
    endtask

    task automatic rd_byte(input logic give_ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(~give_ack);
    endtask
endmodule

// [test/tb_rtc_two_wire_slave_port.sv]
`timescale 1ns/10ps

module tb_rtc_two_wire_slave_port;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic supply_ok_in = 1'b1;
    logic scl;
    logic m_pull;
    logic sda_wire;
    logic sda_out;
    logic sda_oe_n_out;
    logic busy_out;
    logic [5:0] ptr_out;
    logic ack;
    logic [7:0] rd;
    int mismatches = 0;
    int compares = 0;

    always #2 core_clk_in = ~core_clk_in;

    // wired-and with pull-up
    assign sda_wire = (m_pull || (!sda_oe_n_out && !sda_out)) ? 1'b0 : 1'b1;

    rtcs_bus_master u_master (
        .core_clk_in(core_clk_in),
        .sda_in(sda_wire),
        .scl_out(scl),
        .sda_pull_out(m_pull)
    );

    rtcs_slave_port u_dut (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe_n_out(sda_oe_n_out),
        .supply_ok_in(supply_ok_in),
        .ptr_out(ptr_out),
        .busy_out(busy_out)
    );

    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task automatic give_verdict;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic send(input logic [7:0] d, input logic exp_ack);
        u_master.wr_byte(d, ack);
        check(ack, exp_ack, "ack");
        repeat (5) @(negedge core_clk_in);
    endtask

    task automatic take(input logic give_ack, input logic [7:0] exp);
        u_master.rd_byte(give_ack, rd);
        check(rd, exp, "read data");
        repeat (5) @(negedge core_clk_in);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy_out !== 1'b0 && n < 40) begin
            @(negedge core_clk_in);
            n++;
        end
        check(busy_out, 1'b0, "idle after stop");
        if (busy_out !== 1'b0) begin
            give_verdict();
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_write_wrap;
        u_master.start();
        send(8'hD0, 1'b1);
        send(8'hFE, 1'b1);
        check(ptr_out, 8'h3E, "word address");
        send(8'hA5, 1'b1);
        check(ptr_out, 8'h3F, "ptr after write");
        send(8'h5A, 1'b1);
        check(ptr_out, 8'h00, "ptr wrap");
        send(8'hC3, 1'b1);
        check(ptr_out, 8'h01, "ptr after wrap");
        u_master.stop();
        wait_idle();
    endtask

    task automatic t_read_seq;
        u_master.start();
        send(8'hD0, 1'b1);
        send(8'h3E, 1'b1);
        u_master.start();
        send(8'hD1, 1'b1);
        take(1'b1, 8'hA5);
        check(ptr_out, 8'h3F, "ptr after read ack");
        take(1'b1, 8'h5A);
        check(ptr_out, 8'h00, "ptr read wrap");
        take(1'b0, 8'hC3);
        check(ptr_out, 8'h00, "ptr after nack");
        check(sda_oe_n_out, 1'b1, "released after nack");
        u_master.stop();
        wait_idle();
    endtask

    task automatic t_alt_read;
        u_master.start();
        send(8'hD1, 1'b1);
        take(1'b0, 8'hC3);
        u_master.stop();
        wait_idle();
    endtask

    task automatic t_bad_addr;
        u_master.start();
        send(8'hD2, 1'b0);
        check(busy_out, 1'b0, "ignored foreign address");
        check(sda_oe_n_out, 1'b1, "no drive foreign");
        u_master.stop();
        wait_idle();
    endtask

    task automatic t_supply;
        u_master.start();
        send(8'hD0, 1'b1);
        send(8'h05, 1'b1);
        send(8'h77, 1'b1);
        check(ptr_out, 8'h06, "ptr before drop");
        supply_ok_in = 1'b0;
        repeat (8) @(negedge core_clk_in);
        check(ptr_out, 8'h00, "ptr cleared on drop");
        check(busy_out, 1'b0, "access abandoned");
        check(sda_oe_n_out, 1'b1, "released on drop");
        u_master.stop();
        u_master.start();
        send(8'hD0, 1'b0);
        send(8'h05, 1'b0);
        send(8'h11, 1'b0);
        u_master.stop();
        check(ptr_out, 8'h00, "ptr held while low");
        supply_ok_in = 1'b1;
        repeat (10) @(negedge core_clk_in);
        u_master.start();
        send(8'hD0, 1'b1);
        send(8'h05, 1'b1);
        u_master.start();
        send(8'hD1, 1'b1);
        take(1'b0, 8'h77);
        u_master.stop();
        wait_idle();
    endtask

    initial begin
        repeat (100000) @(posedge core_clk_in);
        mismatches++;
        $display("CHECK FAILED t=%0t run timed out", $time);
        give_verdict();
    end

    initial begin
        repeat (8) @(negedge core_clk_in);
        check(ptr_out, 8'h00, "ptr at reset");
        check(sda_oe_n_out, 1'b1, "released at reset");
        nrst_in = 1'b1;
        repeat (6) @(negedge core_clk_in);
        t_write_wrap();
        t_read_seq();
        t_alt_read();
        t_bad_addr();
        t_supply();
        give_verdict();
    end
endmodule
